// >>> rtl/vip_cfg.svh
// offsets, field positions, reset values and counts of the prioritizer
`ifndef VIP_CFG_SVH
`define VIP_CFG_SVH

// register word indices (byte address = index * 4)
`define VIP_W_CTRL1  6'h00
`define VIP_W_CTRL2  6'h01
`define VIP_W_STAT   6'h02
`define VIP_W_CPU    6'h03
`define VIP_W_ISTS   6'h04
`define VIP_W_ICLR   6'h05
`define VIP_W_IEN    6'h06
`define VIP_W_FLAG   6'h10
`define VIP_W_EN     6'h14
`define VIP_W_PRIO   6'h18

// field positions
`define VIP_NEST_BIT 15
`define VIP_ALT_BIT  15

// vector tables and reset address
`define VIP_PRI_BASE   24'h000004
`define VIP_ALT_BASE   24'h000104
`define VIP_RESET_ADDR 24'h000000
`define VIP_USER_FIRST 7'h08

// user slots and the implemented ones among them
`define VIP_NUM_USER  118
`define VIP_IMPL_MASK 118'hCE7EE600601FFFDF7FFF

// fixed entry and return lengths in clock cycles
`define VIP_ENTRY_CYC  4
`define VIP_RETURN_CYC 3

`endif

// >>> rtl/vip_pkg.sv
// types shared by the prioritizer files
package vip_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ENTRY,
        ST_SERVE,
        ST_RETURN
    } vip_state_type;

endpackage

// >>> rtl/vip_arbiter.sv
// picks the highest level pending user source, lowest index on ties
`timescale 1ns/1ns

module vip_arbiter #(
    parameter int N = 118  // user slots
) (
    input  wire logic [N-1:0]      pend,  // enabled pending flags
    input  wire logic [N-1:0][2:0] prio,  // level per slot
    output logic                   valid, // some slot is eligible
    output logic [6:0]             idx,   // winning slot
    output logic [2:0]             lvl    // winning level
);

    // scan from the top so a lower index wins an equal level
    always_comb begin
        valid = 1'b0;
        idx   = 7'h00;
        lvl   = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && prio[i] != 3'h0 && prio[i] >= lvl) begin
                valid = 1'b1;
                idx   = 7'(i);
                lvl   = prio[i];
            end
        end
    end

endmodule

// >>> rtl/vip_ctrl.sv
// vectored interrupt prioritizer with ahb-lite register slave
`timescale 1ns/1ns
`include "vip_cfg.svh"

// What this block does
// - many request lines merge into one request to the core
// - every user source gets one of seven levels (1..7) for arbitration; level 0 keeps it out
// - equal levels: lowest vector position wins
// - primary table at 000004h, 126 entries, traps then interrupts
// - each entry is a 24-bit handler start address
// - each source has its own distinct entry
// - alternate select bit makes every vector use the alternate table
// - alternate table follows primary, same order, vector 0 at 0x000104
// - reset clears registers and leaves handler address at zero
// - 53 maskable and five trap sources; other slots reserved
// - entry and return each take a fixed cycle count
// - request flags set by hardware, cleared only by software
// - acceptance latches vector number and new level
// - level is read-only high bit plus three writable bits
// - nesting disable blocks all nesting but traps over a user handler and freezes the level bits
module vip_ctrl #(
    parameter int STACK_DEPTH = 8,               // nesting depth, max 15
    parameter int ENTRY_CYC   = `VIP_ENTRY_CYC,  // at least 2
    parameter int RETURN_CYC  = `VIP_RETURN_CYC  // at least 1
) (
    input  wire logic        clk,              // core clock
    input  wire logic        rst_b,            // sync reset, low
    input  wire logic        hsel,             // slave select
    input  wire logic [31:0] haddr,            // byte address
    input  wire logic [1:0]  htrans,           // transfer type
    input  wire logic        hwrite,           // write when high
    input  wire logic [2:0]  hsize,            // word only
    input  wire logic [31:0] hwdata,           // write data
    input  wire logic        hready,           // bus ready
    output logic [31:0]      hrdata,           // read data
    output logic             hreadyout,        // slave ready
    output logic             hresp,            // always okay
    input  wire logic [117:0] src_req,         // user requests
    input  wire logic [4:0]  trap_req,         // traps 1..5
    output logic             pm_rd,            // table read strobe
    output logic [23:0]      pm_addr,          // table entry address
    input  wire logic [23:0] pm_rdata,         // entry contents
    output logic             cpu_int_req,      // request to core
    output logic [23:0]      cpu_handler_addr, // handler start
    output logic [6:0]       cpu_vector,       // accepted vector
    input  wire logic        cpu_ack,          // core took request
    input  wire logic        cpu_return,       // core leaves handler
    output logic             ret_done,         // return finished
    output logic [3:0]       cpu_priority,     // current level
    output logic             irq               // event interrupt
);

    localparam int NU = `VIP_NUM_USER;
    localparam logic [NU-1:0] IMPL = `VIP_IMPL_MASK;

    // whole state of the block
    typedef struct packed {
        vip_pkg::vip_state_type      state;
        logic [3:0]                  cnt;
        logic [NU-1:0]               flags;
        logic [NU-1:0]               en;
        logic [NU-1:0][2:0]          prio;
        logic [4:0]                  traps;
        logic                        nest_dis;
        logic                        alt_sel;
        logic [6:0]                  accepted_vector_number;
        logic [3:0]                  new_priority_level;
        logic [3:0]                  cpu_priority_level;
        logic [STACK_DEPTH-1:0][3:0] stk;
        logic [3:0]                  sp;
        logic [2:0]                  ists;
        logic [2:0]                  ien;
        logic                        irq;
        logic                        req;
        logic [23:0]                 haddr;
        logic [23:0]                 pm_addr;
        logic                        pm_rd;
        logic                        ret_done;
        logic                        wr_pend;
        logic [5:0]                  wword;
        logic                        rd_late;
        logic [5:0]                  rword;
        logic [31:0]                 hrdata;
        logic                        hready;
    } vip_regs_type;

    vip_regs_type  r_q;
    vip_regs_type  r_d;
    logic [NU-1:0] pend;
    logic          u_valid;
    logic [6:0]    u_idx;
    logic [2:0]    u_lvl;
    logic          t_valid;
    logic [2:0]    t_vec;
    logic [3:0]    t_lvl;
    logic          user_ok;
    logic          trap_ok;
    logic          room;
    logic          addr_ph;
    logic [6:0]    acc_vec;
    logic [3:0]    acc_lvl;
    logic [2:0]    ev;

    // register read mux
    function automatic logic [31:0] read_word(
        input logic [5:0] w,
        input vip_regs_type s
    );
        logic [31:0] v;
        v = 32'h0;
        case (w)
            `VIP_W_CTRL1: v = {16'h0, s.nest_dis, 9'h0, s.traps, 1'b0};
            `VIP_W_CTRL2: v = {16'h0, s.alt_sel, 15'h0};
            `VIP_W_STAT:  v = {20'h0, s.new_priority_level, 1'b0, s.accepted_vector_number};
            `VIP_W_CPU:   v = {28'h0, s.cpu_priority_level};
            `VIP_W_ISTS:  v = {29'h0, s.ists};
            `VIP_W_IEN:   v = {29'h0, s.ien};
            default:      v = 32'h0;
        endcase
        for (int i = 0; i < NU; i++) begin
            if (w == 6'(`VIP_W_FLAG + i / 32)) begin
                v[i % 32] = s.flags[i];
            end
            if (w == 6'(`VIP_W_EN + i / 32)) begin
                v[i % 32] = s.en[i];
            end
            if (w == 6'(`VIP_W_PRIO + i / 8)) begin
                v[4 * (i % 8) +: 3] = s.prio[i];
            end
        end
        return v;
    endfunction

    // only implemented, enabled, flagged slots compete
    assign pend = r_q.flags & r_q.en & IMPL;

    vip_arbiter #(
        .N (NU)
    ) u_arb (
        .pend  (pend),
        .prio  (r_q.prio),
        .valid (u_valid),
        .idx   (u_idx),
        .lvl   (u_lvl)
    );

    // lowest pending trap vector wins; level 15 minus vector
    always_comb begin
        t_valid = 1'b0;
        t_vec   = 3'h0;
        for (int k = 4; k >= 0; k--) begin
            if (r_q.traps[k]) begin
                t_valid = 1'b1;
                t_vec   = 3'(k + 1);
            end
        end
    end

    assign t_lvl   = 4'hF - {1'b0, t_vec};
    assign trap_ok = t_valid && (t_lvl > r_q.cpu_priority_level);
    // user sources blocked by high bit or low bits at seven
    assign user_ok = u_valid && !r_q.cpu_priority_level[3]
                     && (r_q.cpu_priority_level[2:0] != 3'h7)
                     && (u_lvl > r_q.cpu_priority_level[2:0]);
    assign room    = r_q.sp < 4'(STACK_DEPTH);
    assign acc_vec = trap_ok ? {4'h0, t_vec}
                             : u_idx + `VIP_USER_FIRST;
    assign acc_lvl = trap_ok ? t_lvl : {1'b0, u_lvl};
    assign addr_ph = hsel && hready && htrans[1];

    // next state
    always_comb begin
        r_d          = r_q;
        r_d.pm_rd    = 1'b0;
        r_d.ret_done = 1'b0;
        ev           = 3'h0;

        // data phase of a write
        if (r_q.wr_pend) begin
            case (r_q.wword)
                `VIP_W_CTRL1: begin
                    r_d.nest_dis = hwdata[`VIP_NEST_BIT];
                    r_d.traps    = hwdata[5:1];
                end
                `VIP_W_CTRL2: r_d.alt_sel = hwdata[`VIP_ALT_BIT];
                `VIP_W_CPU: begin
                    if (!r_q.nest_dis) begin
                        r_d.cpu_priority_level[2:0] = hwdata[2:0];
                    end
                end
                `VIP_W_ICLR: r_d.ists = r_q.ists & ~hwdata[2:0];
                `VIP_W_IEN:  r_d.ien = hwdata[2:0];
                default:     r_d.ien = r_q.ien;
            endcase
            for (int i = 0; i < NU; i++) begin
                if (r_q.wword == 6'(`VIP_W_FLAG + i / 32)) begin
                    r_d.flags[i] = hwdata[i % 32];
                end
                if (r_q.wword == 6'(`VIP_W_EN + i / 32)) begin
                    r_d.en[i] = hwdata[i % 32];
                end
                if (r_q.wword == 6'(`VIP_W_PRIO + i / 8)) begin
                    r_d.prio[i] = hwdata[4 * (i % 8) +: 3];
                end
            end
        end

        // hardware sets after the write, so a set wins a clear
        r_d.flags = (r_d.flags | src_req) & IMPL;
        r_d.traps = r_d.traps | trap_req;

        // address phase; a read right behind a write waits once
        r_d.wr_pend = addr_ph && hwrite;
        r_d.wword   = haddr[7:2];
        r_d.hready  = 1'b1;
        r_d.rd_late = 1'b0;
        if (addr_ph && !hwrite) begin
            if (r_q.wr_pend) begin
                r_d.rd_late = 1'b1;
                r_d.hready  = 1'b0;
                r_d.rword   = haddr[7:2];
            end else begin
                r_d.hrdata = read_word(haddr[7:2], r_q);
            end
        end else if (r_q.rd_late) begin
            r_d.hrdata = read_word(r_q.rword, r_q);
        end

        // entry and return sequencer
        case (r_q.state)
            vip_pkg::ST_IDLE: begin
                if (cpu_return && r_q.sp != 4'h0) begin
                    r_d.state = vip_pkg::ST_RETURN;
                    r_d.cnt   = 4'(RETURN_CYC - 1);
                end else if ((trap_ok || user_ok) && room) begin
                    r_d.stk[r_q.sp] = r_q.cpu_priority_level;
                    r_d.sp          = r_q.sp + 4'h1;
                    r_d.accepted_vector_number      = acc_vec;
                    r_d.new_priority_level         = acc_lvl;
                    r_d.cpu_priority_level = r_q.nest_dis ? {trap_ok, 3'h7}
                                           : acc_lvl;
                    r_d.pm_addr = (r_q.alt_sel ? `VIP_ALT_BASE
                                               : `VIP_PRI_BASE)
                                  + {16'h0, acc_vec, 1'b0};
                    r_d.pm_rd   = 1'b1;
                    r_d.cnt     = 4'(ENTRY_CYC - 1);
                    r_d.state   = vip_pkg::ST_ENTRY;
                    ev          = trap_ok ? 3'h2 : 3'h1;
                end
            end
            vip_pkg::ST_ENTRY: begin
                if (r_q.cnt == 4'(ENTRY_CYC - 2)) begin
                    r_d.haddr = pm_rdata;
                end
                if (r_q.cnt == 4'h0) begin
                    r_d.req   = 1'b1;
                    r_d.state = vip_pkg::ST_SERVE;
                end else begin
                    r_d.cnt = r_q.cnt - 4'h1;
                end
            end
            vip_pkg::ST_SERVE: begin
                if (cpu_ack) begin
                    r_d.req   = 1'b0;
                    r_d.state = vip_pkg::ST_IDLE;
                end
            end
            vip_pkg::ST_RETURN: begin
                if (r_q.cnt == 4'h0) begin
                    r_d.sp       = r_q.sp - 4'h1;
                    r_d.cpu_priority_level      = r_q.stk[r_q.sp - 4'h1];
                    r_d.ret_done = 1'b1;
                    r_d.state    = vip_pkg::ST_IDLE;
                    ev           = 3'h4;
                end else begin
                    r_d.cnt = r_q.cnt - 4'h1;
                end
            end
            default: r_d.state = vip_pkg::ST_IDLE;
        endcase

        // sticky events, set wins over clear
        r_d.ists = r_d.ists | ev;
        r_d.irq  = |(r_d.ists & r_d.ien);
    end

    // state register; reset clears everything but hready, which it sets
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_q        <= '0;
            r_q.haddr  <= `VIP_RESET_ADDR;
            r_q.hready <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from the state register, hresp tied low
    assign hrdata           = r_q.hrdata;
    assign hreadyout        = r_q.hready;
    assign hresp            = 1'b0;
    assign pm_rd            = r_q.pm_rd;
    assign pm_addr          = r_q.pm_addr;
    assign cpu_int_req      = r_q.req;
    assign cpu_handler_addr = r_q.haddr;
    assign cpu_vector       = r_q.accepted_vector_number;
    assign ret_done         = r_q.ret_done;
    assign cpu_priority     = r_q.cpu_priority_level;
    assign irq              = r_q.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // acceptance: idle followed by the first entry cycle
    sequence s_accept;
        r_q.state == vip_pkg::ST_IDLE
        ##1 r_q.state == vip_pkg::ST_ENTRY;
    endsequence

    sequence s_ret_go;
        r_q.state == vip_pkg::ST_IDLE && cpu_return && r_q.sp != 4'h0;
    endsequence

    a_entry_fixed_len: assert property (
        s_accept |=> (r_q.state == vip_pkg::ST_ENTRY)[*3] ##1 r_q.req)
    else $error("entry length wrong");

    a_return_fixed_len: assert property (
        s_ret_go |=> (r_q.state == vip_pkg::ST_RETURN)[*3]
        ##1 (r_q.ret_done && r_q.state == vip_pkg::ST_IDLE))
    else $error("return length wrong");

    a_status_latch: assert property (
        s_accept |-> r_q.accepted_vector_number == $past(acc_vec)
                     && r_q.new_priority_level == $past(acc_lvl))
    else $error("accepted status not latched");

    a_table_addr: assert property (
        r_q.pm_rd |-> r_q.pm_addr == (($past(r_q.alt_sel) ?
            `VIP_ALT_BASE : `VIP_PRI_BASE) + {16'h0, r_q.accepted_vector_number, 1'b0}))
    else $error("entry address wrong");

    a_handler_fetch: assert property (
        s_accept |-> ##2 r_q.haddr == $past(pm_rdata))
    else $error("handler address not fetched");

    a_user_blocked: assert property (
        s_accept ##0 r_q.accepted_vector_number >= `VIP_USER_FIRST
        |-> !$past(r_q.cpu_priority_level[3]) && $past(r_q.cpu_priority_level[2:0]) != 3'h7
            && r_q.new_priority_level > $past(r_q.cpu_priority_level))
    else $error("blocked user source accepted");

    a_flag_sticky: assert property (
        |($past(r_q.flags) & ~r_q.flags)
        |-> $past(r_q.wr_pend && r_q.wword[5:2] == 4'h4))
    else $error("flag cleared without write");

    a_impl_only: assert property (
        (r_q.flags & ~IMPL) == '0)
    else $error("reserved slot flagged");

    // the winner is a real pending slot at its own nonzero level
    a_winner_pending: assert property (
        u_valid |-> pend[u_idx] && r_q.prio[u_idx] == u_lvl
                    && u_lvl != 3'h0)
    else $error("arbiter winner not pending");

    a_nest_lock: assert property (
        $past(r_q.nest_dis && r_q.wr_pend && r_q.wword == `VIP_W_CPU
              && r_q.state != vip_pkg::ST_RETURN && !trap_ok && !user_ok)
        |-> r_q.cpu_priority_level == $past(r_q.cpu_priority_level))
    else $error("level written while nesting disabled");

    a_req_rise: assert property (
        $rose(r_q.req) |-> $past(r_q.state) == vip_pkg::ST_ENTRY
                           && $past(r_q.cnt) == 4'h0)
    else $error("request raised out of sequence");

endmodule

// >>> verif/vip_core_model.sv
// core and program memory stand-in facing the prioritizer
`timescale 1ns/1ns

module vip_core_model (
    input  wire logic        clk,         // core clock
    input  wire logic        rst_b,       // sync reset, low
    input  wire logic        pm_rd,       // table read strobe
    input  wire logic [23:0] pm_addr,     // table entry address
    output logic      [23:0] pm_rdata,    // entry contents
    input  wire logic        cpu_int_req, // request from block
    output logic             cpu_ack,     // request taken pulse
    input  wire logic [3:0]  ack_wait     // cycles before ack
);
    logic [3:0] wait_q;

    // entry word differs per address so a wrong slot shows
    // tables not mirrored: the bench switches between both
    // reserved slots are never fetched, so no reset handler
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pm_rdata <= 24'h000000;
        end else if (pm_rd) begin
            pm_rdata <= pm_addr ^ 24'h5A0000;
        end else begin
            pm_rdata <= ~pm_rdata; // released, no stale value
        end
    end

    // takes the request after a chosen wait, one-cycle ack
    always_ff @(posedge clk) begin
        if (!rst_b || !cpu_int_req || cpu_ack) begin
            cpu_ack <= 1'b0;
            wait_q  <= 4'h0;
        end else if (wait_q == ack_wait) begin
            cpu_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// >>> verif/vip_ctrl_tb.sv
// self-checking bench for the vectored interrupt prioritizer
`timescale 1ns/1ns
`define CHK(a, e) \
    begin \
        check_count++; \
        if ((a) !== (e)) begin \
            miscompares++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); \
        end \
    end

module vip_ctrl_tb;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic [117:0] src_req = '0;
    logic [4:0]   trap_req = 5'h00;
    logic         pm_rd;
    logic [23:0]  pm_addr;
    logic [23:0]  pm_rdata;
    logic [23:0]  cpu_handler_addr;
    logic         cpu_int_req;
    logic         cpu_ack;
    logic         ret_done;
    logic         irq;
    logic [6:0]   cpu_vector;
    logic         cpu_return = 1'b0;
    logic [3:0]   cpu_priority;
    logic [3:0]   ack_wait = 4'h0;
    logic [31:0]  rd;
    int           miscompares = 0;
    int           check_count = 0;
    int           cycles = 0;
    int           ent_ref;
    int           ret_ref;
    int           n;

    always #20 clk = ~clk;

    vip_ctrl DUT (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .src_req(src_req), .trap_req(trap_req),
        .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .cpu_int_req(cpu_int_req), .cpu_handler_addr(cpu_handler_addr),
        .cpu_vector(cpu_vector), .cpu_ack(cpu_ack),
        .cpu_return(cpu_return), .ret_done(ret_done),
        .cpu_priority(cpu_priority), .irq(irq)
    );

    vip_core_model core (
        .clk(clk), .rst_b(rst_b), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .cpu_int_req(cpu_int_req),
        .cpu_ack(cpu_ack), .ack_wait(ack_wait)
    );

    // verdict and end of run
    task automatic test_done;
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done;
        end
    end

    // one single ahb-lite transfer, read data left in rd
    task automatic bus(input logic w, input logic [31:0] a, d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [31:0] a, e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // one-cycle request pulse on user and trap lines
    task automatic pulse(input logic [117:0] s, input logic [4:0] t);
        src_req  <= s;
        trap_req <= t;
        @(posedge clk);
        src_req  <= '0;
        trap_req <= 5'h00;
    endtask

    // follows one accept; c is cycles from fetch to request
    task automatic svc(input logic [6:0] v, input logic [23:0] base,
                       output int c);
        logic [23:0] ea;
        ea = base + {16'h0000, v, 1'b0};
        while (pm_rd !== 1'b1)
            @(posedge clk);
        `CHK(pm_addr, ea)
        c = 0;
        while (cpu_int_req !== 1'b1) begin
            @(posedge clk);
            c++;
        end
        `CHK(cpu_vector, v)
        `CHK(cpu_handler_addr, ea ^ 24'h5A0000)
        while (cpu_int_req !== 1'b0)
            @(posedge clk);
    endtask

    // core leaves the handler; c is cycles until done
    task automatic ret(output int c);
        cpu_return <= 1'b1;
        @(posedge clk);
        cpu_return <= 1'b0;
        c = 1;
        while (ret_done !== 1'b1) begin
            @(posedge clk);
            c++;
        end
    endtask

    task automatic t_reset;
        `CHK(cpu_handler_addr, 24'h000000)
        `CHK(cpu_int_req, 1'b0)
        `CHK(hresp, 1'b0)
        rdchk(32'h08, 32'h0);
        rdchk(32'h3C, 32'h0);
    endtask

    // levels 3,5,5 on slots 0..2: level first, then lowest slot
    task automatic t_prio;
        wr(32'h50, 32'h7);
        wr(32'h60, 32'h553);
        pulse(118'h7, 5'h00);
        svc(7'h09, 24'h000004, ent_ref);
        `CHK(cpu_priority, 4'h5)
        rdchk(32'h08, 32'h509);
        wr(32'h40, 32'h5);
        ret(ret_ref);
        ack_wait <= 4'h5;
        svc(7'h0A, 24'h000004, n);
        `CHK(n, ent_ref)
        wr(32'h40, 32'h1);
        ret(n);
        `CHK(n, ret_ref)
        ack_wait <= 4'h0;
        svc(7'h08, 24'h000004, n);
        wr(32'h40, 32'h0);
        ret(n);
    endtask

    task automatic t_alt;
        wr(32'h04, 32'h8000);
        pulse(118'h1, 5'h00);
        svc(7'h08, 24'h000104, n);
        `CHK(n, ent_ref)
        wr(32'h40, 32'h0);
        ret(n);
        wr(32'h04, 32'h0);
    endtask

    // every trap, traps 2 and 4 through the alternate table
    task automatic t_trap;
        for (int k = 0; k < 5; k++) begin
            wr(32'h04, k[0] ? 32'h8000 : 32'h0);
            pulse(118'h0, 5'h01 << k);
            svc(7'(k + 1), k[0] ? 24'h000104 : 24'h000004, n);
            `CHK(n, ent_ref)
            `CHK(cpu_priority[3], 1'b1)
            wr(32'h00, 32'h0);
            ret(n);
        end
        wr(32'h04, 32'h0);
    endtask

    // level 7 blocks, flags stick, reserved slot never sets
    task automatic t_mask;
        wr(32'h0C, 32'hF);
        rdchk(32'h0C, 32'h7);
        wr(32'h50, 32'h8001);
        pulse(118'h8001, 5'h00);
        repeat (12) @(posedge clk);
        `CHK(cpu_int_req, 1'b0)
        rdchk(32'h40, 32'h1);
        wr(32'h00, 32'h8000);
        wr(32'h0C, 32'h0);
        rdchk(32'h0C, 32'h7);
        wr(32'h00, 32'h0);
        wr(32'h0C, 32'h0);
        svc(7'h08, 24'h000004, n);
        wr(32'h40, 32'h0);
        ret(n);
    endtask

    // event interrupt: masked, enabled, cleared
    task automatic t_irq;
        wr(32'h14, 32'h7);
        wr(32'h18, 32'h0);
        pulse(118'h1, 5'h00);
        svc(7'h08, 24'h000004, n);
        `CHK(irq, 1'b0)
        rdchk(32'h10, 32'h1);
        wr(32'h18, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(32'h14, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rdchk(32'h10, 32'h0);
        wr(32'h40, 32'h0);
        ret(n);
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_prio;
        t_alt;
        t_trap;
        t_mask;
        t_irq;
        test_done;
    end
endmodule
